// >>> verilog/fsp_pkg.sv
/*
  Constants and types for the flash self-program mode control block.
  Assumes a 40 MHz core clock and an 8-bit register port.
*/
package fsp_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] A_UNLOCK   = 4'h0; // Write only
  localparam logic [ADDR_W-1:0] A_STATUS   = 4'h1; // Protection error flag
  localparam logic [ADDR_W-1:0] A_MODE     = 4'h2; // Guarded mode control
  localparam logic [ADDR_W-1:0] A_COMMAND  = 4'h3; // Flash command
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 4'h4; // Sticky events
  localparam logic [ADDR_W-1:0] A_IRQ_CLR  = 4'h5; // Write one to clear
  localparam logic [ADDR_W-1:0] A_IRQ_EN   = 4'h6; // Event enables

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] UNLOCK_KEY  = 8'ha5;
  localparam int                MODE_BIT    = 0;
  localparam int                MIRROR_LSB  = 2;
  localparam int                MIRROR_W    = 5;
  localparam int                PERR_BIT    = 0;
  localparam int                CMD_W       = 3;
  localparam logic              MODE_RST    = 1'b0;
  localparam logic [CMD_W-1:0]  CMD_RST     = 3'h0;

  localparam int                IRQ_W       = 2;
  localparam int                IRQ_PERR    = 0; // Protection error
  localparam int                IRQ_HREL    = 1; // Halt auto-released

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 40000;
  localparam int HALT_REL_US    = 10;    // Longest wait, microseconds
  localparam int HALT_REL_EXTRA = 2;     // Extra cpu clocks
  localparam int HALT_REL_CYC   =
    (HALT_REL_US * CLK_KHZ) / 1000 + HALT_REL_EXTRA;
  localparam int HALT_CNT_W     = 9;
  localparam logic [1:0] MIRROR_CAP_CNT = 2'h2; // Synchroniser depth

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_KEY  = 2'b01,
    SEQ_VAL  = 2'b10,
    SEQ_INV  = 2'b11
  } fsp_seq_t;

  typedef enum logic [1:0] {
    HLT_RUN  = 2'b00,
    HLT_STBY = 2'b01,
    HLT_PROG = 2'b10
  } fsp_halt_t;

endpackage

// >>> verilog/fsp_unlock_if.sv
/*
  Bundle between the register front end and the unlock sequencer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface fsp_unlock_if;
  import fsp_pkg::*;

  logic              store;      // Any register write this cycle
  logic              hit_key;    // Write targets the unlock register
  logic              hit_mode;   // Write targets mode control
  logic [DATA_W-1:0] wdata;      // Write data
  logic              commit;     // Pulse: mode write accepted
  logic [DATA_W-1:0] commit_val; // Value to store on commit
  logic              err;        // Pulse: sequence broken

  modport ctrl (output store, hit_key, hit_mode, wdata,
                input  commit, commit_val, err);
  modport seq  (input  store, hit_key, hit_mode, wdata,
                output commit, commit_val, err);
endinterface

// >>> verilog/fsp_unlock_seq.sv
/*
  Unlock sequencer guarding the mode control register.
  Assumes store strobes come from the same clock domain.
*/
`timescale 1ns/10ps
module fsp_unlock_seq
  import fsp_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, active high
  fsp_unlock_if.seq ul  // Store stream in, verdict out
);

  fsp_seq_t          st_q, st_d;
  logic [DATA_W-1:0] val_q, val_d;
  logic              commit_d, err_d;

  // ----------------------------------------------------------------
  // Key, value, inverse, value
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    val_d    = val_q;
    commit_d = 1'b0;
    err_d    = 1'b0;
    if (ul.store) begin
      case (st_q)
        SEQ_IDLE: begin
          if (ul.hit_key) begin
            if (ul.wdata == UNLOCK_KEY) begin
              st_d = SEQ_KEY;
            end else begin
              err_d = 1'b1;
            end
          end else if (ul.hit_mode) begin
            err_d = 1'b1;
          end
        end
        SEQ_KEY: begin
          if (ul.hit_mode) begin
            val_d = ul.wdata;
            st_d  = SEQ_VAL;
          end else begin
            err_d = 1'b1;
            st_d  = SEQ_IDLE;
          end
        end
        SEQ_VAL: begin
          if (ul.hit_mode && ul.wdata == ~val_q) begin
            st_d = SEQ_INV;
          end else begin
            err_d = 1'b1;
            st_d  = SEQ_IDLE;
          end
        end
        SEQ_INV: begin
          if (ul.hit_mode && ul.wdata == val_q) begin
            commit_d = 1'b1;
          end else begin
            err_d = 1'b1;
          end
          st_d = SEQ_IDLE;
        end
        default: st_d = SEQ_IDLE;
      endcase
    end
  end

  // State and verdict registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q          <= SEQ_IDLE;
      val_q         <= 8'h00;
      ul.commit     <= 1'b0;
      ul.commit_val <= 8'h00;
      ul.err        <= 1'b0;
    end else begin
      st_q          <= st_d;
      val_q         <= val_d;
      ul.commit     <= commit_d;
      ul.commit_val <= ul.wdata;
      ul.err        <= err_d;
    end
  end

endmodule

// >>> verilog/fsp_mode_ctrl.sv
/*
  Flash self-program mode control: guarded mode register, halt
  handling with automatic release, protect byte mirror, flash
  command register, protection error flag and event interrupt.
  Assumes a 40 MHz clock, a CPU-side halt pulse on the same clock,
  and a protect byte that arrives asynchronously on pins.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - Mode 0: halt enters plain standby
// - Mode 1: halt runs loaded flash operation
// - Mode bit clears to 0 on reset
// - Protect byte mirrored into bits 2..6
// - Mirror bits ignore software writes
// - Post-entry halt released within 10us+2 clocks
// - Bits 7 and 1 read zero
// - Mode write needs key, value, inverse, value
// - Broken order keeps register, sets error flag
module fsp_mode_ctrl
  import fsp_pkg::*;
#(
  parameter int HALT_CYC = HALT_REL_CYC // Cycles to halt release
)
(
  input  wire logic                clk,          // Core clock, 40 MHz
  input  wire logic                rst,          // Async reset, high
  input  wire logic [ADDR_W-1:0]   addr,         // Register address
  input  wire logic [DATA_W-1:0]   wdata,        // Write data
  input  wire logic                wr,           // Write strobe
  input  wire logic                rd,           // Read strobe
  output logic      [DATA_W-1:0]   rdata_q,      // Read data, next cycle
  input  wire logic                halt_req,     // CPU executes halt
  input  wire logic                wake_req,     // Standby wake event
  input  wire logic [MIRROR_W-1:0] protect_pins, // Protect byte value
  output logic                     self_prog_q,  // Mode select bit
  output logic                     standby_q,    // Plain standby
  output logic                     flash_busy_q, // Flash halt running
  output logic                     flash_start_q,// Pulse: start op
  output logic                     halt_rel_q,   // Pulse: flash halt ended
  output logic      [CMD_W-1:0]    flash_cmd_q,  // Flash command
  output logic                     irq_q         // Interrupt level
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fsp_unlock_if ul ();

  logic [MIRROR_W-1:0]   prot_meta_q;
  logic [MIRROR_W-1:0]   prot_sync_q;
  logic [MIRROR_W-1:0]   mirror_q;
  logic [1:0]            cap_cnt_q;
  logic                  perr_q;
  logic [IRQ_W-1:0]      irq_stat_q;
  logic [IRQ_W-1:0]      irq_en_q;
  logic [IRQ_W-1:0]      irq_ev;
  logic [IRQ_W-1:0]      irq_clr;
  fsp_halt_t             hst_q;
  logic [HALT_CNT_W-1:0] hcnt_q;
  logic                  hrel_ev;
  logic                  go_prog;
  logic                  go_stby;
  logic [DATA_W-1:0]     mode_view;
  logic [DATA_W-1:0]     stat_view;
  logic [DATA_W-1:0]     cmd_view;
  logic [DATA_W-1:0]     irqs_view;
  logic [DATA_W-1:0]     irqe_view;

  localparam logic [HALT_CNT_W-1:0] HALT_LAST =
    HALT_CNT_W'(HALT_CYC - 1);

  // Register write decode
  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    return wr && (addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Unlock sequencer hookup
  // ----------------------------------------------------------------
  // Every write counts as a store for the sequence
  assign ul.store    = wr;
  assign ul.hit_key  = (addr == A_UNLOCK);
  assign ul.hit_mode = (addr == A_MODE);
  assign ul.wdata    = wdata;

  fsp_unlock_seq u_seq (
    .clk (clk),
    .rst (rst),
    .ul  (ul.seq)
  );

  // ----------------------------------------------------------------
  // Mode select bit
  // ----------------------------------------------------------------
  // Only a committed sequence changes the mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      self_prog_q <= MODE_RST;
    end else if (ul.commit) begin
      self_prog_q <= ul.commit_val[MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Protect byte mirror
  // ----------------------------------------------------------------
  // Two-stage synchroniser on the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_meta_q <= 5'h00;
      prot_sync_q <= 5'h00;
    end else begin
      prot_meta_q <= protect_pins;
      prot_sync_q <= prot_meta_q;
    end
  end

  // Edges since release, until the mirror has captured the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_cnt_q <= 2'h0;
    end else if (cap_cnt_q <= MIRROR_CAP_CNT) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
    end
  end

  // Capture once after reset release, then hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mirror_q <= 5'h00;
    end else if (cap_cnt_q == MIRROR_CAP_CNT) begin
      mirror_q <= prot_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Flash command register
  // ----------------------------------------------------------------
  // Plain read/write; software clears it around mode switches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cmd_q <= CMD_RST;
    end else if (wr_hit(A_COMMAND)) begin
      flash_cmd_q <= wdata[CMD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Protection error flag
  // ----------------------------------------------------------------
  // Cleared by writing 0; a new error in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perr_q <= 1'b0;
    end else if (ul.err) begin
      perr_q <= 1'b1;
    end else if (wr_hit(A_STATUS) && !wdata[PERR_BIT]) begin
      perr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Halt handling
  // ----------------------------------------------------------------
  // A halt is only taken from the run state
  assign go_prog = (hst_q == HLT_RUN) && halt_req && self_prog_q;
  assign go_stby = (hst_q == HLT_RUN) && halt_req && !self_prog_q;
  assign hrel_ev = (hst_q == HLT_PROG) && (hcnt_q == HALT_LAST);

  // Normal mode sleeps; programming mode runs a timed flash halt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hst_q <= HLT_RUN;
    end else begin
      case (hst_q)
        HLT_RUN: begin
          if (go_prog) begin
            hst_q <= HLT_PROG;
          end else if (go_stby) begin
            hst_q <= HLT_STBY;
          end
        end
        HLT_STBY: begin
          if (wake_req) begin
            hst_q <= HLT_RUN;
          end
        end
        HLT_PROG: begin
          if (hrel_ev) begin
            hst_q <= HLT_RUN;
          end
        end
        default: begin
          hst_q <= HLT_RUN;
        end
      endcase
    end
  end

  // Flash halt length; rests at zero outside the flash halt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcnt_q <= '0;
    end else if (hst_q != HLT_PROG) begin
      hcnt_q <= '0;
    end else if (!hrel_ev) begin
      hcnt_q <= hcnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Halt outputs
  // ----------------------------------------------------------------
  // Plain standby level, held until a wake event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= go_stby
                   || ((hst_q == HLT_STBY) && !wake_req);
    end
  end

  // Flash halt level with its start and release pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_busy_q  <= 1'b0;
      flash_start_q <= 1'b0;
      halt_rel_q    <= 1'b0;
    end else begin
      flash_busy_q  <= go_prog || ((hst_q == HLT_PROG) && !hrel_ev);
      flash_start_q <= go_prog;
      halt_rel_q    <= hrel_ev;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and output
  // ----------------------------------------------------------------
  // Event vector and clear mask
  always_comb begin
    irq_ev           = '0;
    irq_ev[IRQ_PERR] = ul.err;
    irq_ev[IRQ_HREL] = hrel_ev;
    irq_clr          = wr_hit(A_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0;
  end

  // Sticky bits, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  // Enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= '0;
    end else if (wr_hit(A_IRQ_EN)) begin
      irq_en_q <= wdata[IRQ_W-1:0];
    end
  end

  // Level output from registered status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Byte views; unused bits are fixed zero, mirror has no write path
  assign mode_view = {1'b0, mirror_q, 1'b0, self_prog_q};
  assign stat_view = {7'h00, perr_q};
  assign cmd_view  = {5'h00, flash_cmd_q};
  assign irqs_view = {6'h00, irq_stat_q};
  assign irqe_view = {6'h00, irq_en_q};

  // Registered read; unmapped and write-only addresses read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        A_STATUS:   rdata_q <= stat_view;
        A_MODE:     rdata_q <= mode_view;
        A_COMMAND:  rdata_q <= cmd_view;
        A_IRQ_STAT: rdata_q <= irqs_view;
        A_IRQ_EN:   rdata_q <= irqe_view;
        default:    rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

endmodule

// >>> test/fsp_mode_ctrl_assertions.sv
/*
  Port checks for the flash self-program mode control block.
  Assumes the bind below and a single clock domain.
*/
`timescale 1ns/10ps
module fsp_chk
  import fsp_pkg::*;
#(
  parameter int HALT_CYC = HALT_REL_CYC // Halt length in cycles
)
(
  input wire logic              clk,           // Core clock
  input wire logic              rst,           // Async reset
  input wire logic [ADDR_W-1:0] addr,          // Address
  input wire logic [DATA_W-1:0] wdata,         // Write data
  input wire logic              wr,            // Write strobe
  input wire logic              rd,            // Read strobe
  input wire logic [DATA_W-1:0] rdata_q,       // Read data
  input wire logic              halt_req,      // Halt request
  input wire logic              wake_req,      // Wake request
  input wire logic              self_prog_q,   // Mode bit
  input wire logic              standby_q,     // Plain standby
  input wire logic              flash_busy_q,  // Flash halt
  input wire logic              flash_start_q, // Start pulse
  input wire logic              halt_rel_q     // Release pulse
);
  // ----------------------------------------------------------------
  // Helper count and clocking
  // ----------------------------------------------------------------
  logic [HALT_CNT_W-1:0] busy_q;

  // Consecutive busy cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_q <= '0;
    else busy_q <= flash_busy_q ? busy_q + 1'b1 : '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_unlock;
    wr && addr == A_UNLOCK && wdata == UNLOCK_KEY
    ##1 wr && addr == A_MODE
    ##1 wr && addr == A_MODE && wdata == ~$past(wdata)
    ##1 wr && addr == A_MODE && wdata == $past(wdata, 2);
  endsequence

  property p_reset_mode; $fell(rst) |-> !self_prog_q; endproperty
  property p_rd_idle; !$past(rd) |-> rdata_q == '0; endproperty
  property p_bits_zero;
    $past(rd) && $past(addr) == A_MODE
      |-> !rdata_q[7] && !rdata_q[1] && rdata_q[0] == $past(self_prog_q);
  endproperty
  property p_unlock_set;
    s_unlock ##0 wdata[MODE_BIT] |-> ##[1:3] self_prog_q;
  endproperty
  property p_standby;
    halt_req && !self_prog_q && !standby_q && !flash_busy_q
      |=> standby_q && !flash_start_q;
  endproperty
  property p_stby_hold; standby_q && !wake_req |=> standby_q; endproperty
  property p_prog_start;
    halt_req && self_prog_q && !standby_q && !flash_busy_q
      |=> flash_start_q && flash_busy_q;
  endproperty
  property p_rel_time;
    halt_rel_q |-> busy_q == HALT_CYC && !flash_busy_q;
  endproperty
  property p_busy_max; flash_busy_q |-> busy_q <= HALT_CYC - 1; endproperty

  a_reset_mode: assert property (p_reset_mode)
    else $error("mode bit set after reset");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_bits_zero: assert property (p_bits_zero)
    else $error("mode read has bad fixed bits");
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlocked mode write not taken");
  a_standby: assert property (p_standby)
    else $error("halt in normal mode not standby");
  a_stby_hold: assert property (p_stby_hold)
    else $error("standby left without wake");
  a_prog_start: assert property (p_prog_start)
    else $error("halt in program mode did not start");
  a_rel_time: assert property (p_rel_time)
    else $error("halt release at wrong time");
  a_busy_max: assert property (p_busy_max)
    else $error("flash halt held too long");

  c_unlock: cover property (s_unlock);
  c_release: cover property (halt_rel_q);
  c_standby: cover property ($rose(standby_q));
endmodule

bind fsp_mode_ctrl fsp_chk #(.HALT_CYC(HALT_CYC)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .halt_req(halt_req), .wake_req(wake_req),
  .self_prog_q(self_prog_q), .standby_q(standby_q),
  .flash_busy_q(flash_busy_q), .flash_start_q(flash_start_q),
  .halt_rel_q(halt_rel_q));

// >>> test/tb_top.sv
/*
  Self-checking bench for the mode control block.
  Assumes the port checker is bound in from its own file.
*/
`timescale 1ns/10ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin \
  fail_count++; $display("wrong value at %0t: %h vs %h", \
  $time, act, exp); end end
module tb_top
  import fsp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int HC = 8; // Short halt for simulation
  logic                clk, rst, wr, rd, halt_req, wake_req;
  logic                self_prog_q, standby_q, flash_busy_q;
  logic                flash_start_q, halt_rel_q, irq_q;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata, rdata_q;
  logic [MIRROR_W-1:0] protect_pins;
  logic [CMD_W-1:0]    flash_cmd_q;
  int                  fail_count, checked, n;

  fsp_mode_ctrl #(.HALT_CYC(HC)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .halt_req(halt_req),
    .wake_req(wake_req), .protect_pins(protect_pins),
    .self_prog_q(self_prog_q), .standby_q(standby_q),
    .flash_busy_q(flash_busy_q), .flash_start_q(flash_start_q),
    .halt_rel_q(halt_rel_q), .flash_cmd_q(flash_cmd_q), .irq_q(irq_q));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle(input int c);
    wr <= 1'b0;
    rd <= 1'b0;
    halt_req <= 1'b0;
    repeat (c) @(posedge clk);
  endtask

  // Read slot, then data in the following cycle only
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK(rdata_q, e)
  endtask

  task automatic unlock(input logic [DATA_W-1:0] v);
    wr_reg(A_UNLOCK, UNLOCK_KEY);
    wr_reg(A_MODE, v);
    wr_reg(A_MODE, ~v);
    wr_reg(A_MODE, v);
    idle(3);
  endtask

  task automatic pulse_halt();
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic conclude();
    $display("mismatches %0d, checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0;
    wdata = '0; halt_req = 1'b0; wake_req = 1'b0;
    protect_pins = 5'h15; fail_count = 0; checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    idle(4);
    // Reset state, mirror, empty places
    rd_chk(A_MODE, 8'h54);
    rd_chk(4'hf, 8'h00);
    rd_chk(A_UNLOCK, 8'h00);
    wr_reg(A_IRQ_EN, 8'h03);
    rd_chk(A_IRQ_EN, 8'h03);
    // Enter program mode with stray bits in the value
    wr_reg(A_COMMAND, 8'h00);
    unlock(8'h83);
    // Post-entry halt ends by itself, then settle before programming
    pulse_halt();
    idle(HC + 2);
    `CHK(flash_busy_q, 1'b0)
    idle(8 * CLK_KHZ / 1000);
    wr_reg(A_IRQ_CLR, 8'h02);
    rd_chk(A_MODE, 8'h55);
    rd_chk(A_STATUS, 8'h00);
    // Broken orders: bad key, bad inverse, bad repeat, foreign store
    for (int k = 0; k < 4; k++) begin
      wr_reg(A_UNLOCK, k == 0 ? 8'h5a : UNLOCK_KEY);
      if (k == 3) wr_reg(A_COMMAND, 8'h00);
      wr_reg(A_MODE, 8'h82);
      wr_reg(A_MODE, k == 1 ? 8'h82 : 8'h7d);
      wr_reg(A_MODE, k == 2 ? 8'h80 : 8'h82);
      idle(4);
      `CHK(irq_q, 1'b1)
      rd_chk(A_MODE, 8'h55);
      rd_chk(A_STATUS, 8'h01);
      wr_reg(A_STATUS, 8'h00);
      wr_reg(A_IRQ_CLR, 8'h01);
      idle(2);
      rd_chk(A_STATUS, 8'h00);
      `CHK(irq_q, 1'b0)
    end
    // Loaded command, then halt starts the flash operation
    wr_reg(A_COMMAND, 8'hfd);
    idle(1);
    `CHK(flash_cmd_q, 3'h5)
    rd_chk(A_COMMAND, 8'h05);
    pulse_halt();
    `CHK(flash_start_q, 1'b1)
    `CHK(flash_busy_q, 1'b1)
    n = 1;
    while (halt_rel_q !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      conclude();
    end
    // Release launched HC edges after the halt, seen one edge later
    `CHK(n, HC + 1)
    `CHK(flash_busy_q, 1'b0)
    idle(3);
    `CHK(irq_q, 1'b1)
    rd_chk(A_IRQ_STAT, 8'h02);
    wr_reg(A_IRQ_CLR, 8'h02);
    idle(2);
    `CHK(irq_q, 1'b0)
    // Back to normal mode: halt is plain standby
    wr_reg(A_COMMAND, 8'h00);
    unlock(8'h7c);
    rd_chk(A_MODE, 8'h54);
    pulse_halt();
    `CHK(standby_q, 1'b1)
    `CHK(flash_start_q, 1'b0)
    idle(20);
    `CHK(standby_q, 1'b1)
    `CHK(flash_busy_q, 1'b0)
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    idle(2);
    `CHK(standby_q, 1'b0)
    // Reset in program mode with new protect byte
    wr_reg(A_COMMAND, 8'h00);
    unlock(8'h01);
    wr_reg(A_COMMAND, 8'h05);
    idle(1);
    protect_pins <= 5'h0a;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    idle(4);
    rd_chk(A_MODE, 8'h28);
    rd_chk(A_COMMAND, 8'h00);
    conclude();
  end
endmodule
